// *** mbc_pkg.sv ***
// Shared constants, word layout and request types for the memory bank controller
package mbc_pkg;

	// ==================================================================
	// Widths
	localparam int unsigned ADDR_W  = 16;
	localparam int unsigned HALF_W  = 16;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned EXEC_W  = 2;
	localparam int unsigned NPORTS  = 4;
	localparam int unsigned WORDS   = 16384;
	localparam int unsigned SCR_N   = 16;
	localparam int unsigned STRAP_W = 6;

	// ==================================================================
	// Timing, printed figures in ns and derived cycle counts
	localparam int unsigned CLK_NS    = 100;
	localparam int unsigned CYCLE_NS  = 2000;
	localparam int unsigned ACCESS_NS = 750;
	localparam int unsigned SCR_NS    = 250;
	// Least times round up to whole cycles
	localparam int unsigned CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned ACC_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SCR_CYC   = (SCR_NS + CLK_NS - 1) / CLK_NS;
	// Fast paths need one spare cycle so an acked port is not re-granted
	localparam int unsigned FAST_END  = SCR_CYC + 1;
	localparam int unsigned CNT_W     = 5;

	// ==================================================================
	// Reserved low-address map (octal 0-7, 10-27, 40-60, 61-460)
	localparam logic [15:0] A_ACC     = 16'h0000;
	localparam logic [15:0] A_SAVE    = 16'h0001;
	localparam logic [15:0] A_IDX_LO  = 16'h0002;
	localparam logic [15:0] A_IDX_HI  = 16'h0007;
	localparam logic [15:0] A_SCR_LO  = 16'h0008;
	localparam logic [15:0] A_SCR_HI  = 16'h0017;
	localparam logic [15:0] A_INTI_LO = 16'h0020;
	localparam logic [15:0] A_INTI_HI = 16'h0030;
	localparam logic [15:0] A_INTX_LO = 16'h0031;
	localparam logic [15:0] A_INTX_HI = 16'h0130;

	// Bank-select field position for 8192 and 16,384 word banks
	localparam int unsigned SMALL_LSB = 13;
	localparam int unsigned BIG_LSB   = 14;

	// ==================================================================
	// Types
	typedef enum logic {OP_READ, OP_WRITE} mbc_op_t;

	typedef enum logic [2:0] {
		Z_CORE, Z_HREG, Z_SCR, Z_INTI, Z_INTX
	} mbc_zone_t;

	typedef struct packed {
		mbc_op_t              op;
		logic                 sel_hi;
		logic                 sel_lo;
		logic                 sel_exec;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    wdata;
		logic [EXEC_W-1:0]    wexec;
	} mbc_req_t;

	typedef struct packed {
		logic [DATA_W-1:0]    rdata;
		logic [EXEC_W-1:0]    rexec;
		logic [1:0]           perr;
	} mbc_rsp_t;

	// Stored 36-bit word: per half a parity bit, an exec bit and 16 data bits
	typedef struct packed {
		logic                 par_hi;
		logic                 exec_hi;
		logic [HALF_W-1:0]    data_hi;
		logic                 par_lo;
		logic                 exec_lo;
		logic [HALF_W-1:0]    data_lo;
	} mbc_word_t;

endpackage

// *** mbc_arb.sv ***
// Fixed-priority arbiter, lowest port number wins
`timescale 1ns/100ps
module mbc_arb #(
	parameter int unsigned N = 4
) (
	// Requests
	input  wire logic [N-1:0]         i_req,
	input  wire logic                 i_en,
	// Grant
	output logic      [N-1:0]         o_gnt,
	output logic      [$clog2(N)-1:0] o_idx,
	output logic                      o_any
);

	// ==================================================================
	// Priority pick; a loser keeps its request up and waits its turn
	always_comb begin
		o_gnt = '0;
		o_idx = '0;
		o_any = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_en && i_req[i]) begin
				o_gnt = '0;
				o_gnt[i] = 1'b1;
				o_idx = ($clog2(N))'(i);
				o_any = 1'b1;
			end
		end
	end

endmodule

// *** mbc_par.sv ***
// Odd parity generation and checking for both half-words of a word
`timescale 1ns/100ps
module mbc_par (
	// Write side
	input  wire logic [31:0]        i_wdata,
	// Read side
	input  wire mbc_pkg::mbc_word_t i_rword,
	// Results
	output logic      [1:0]         o_par,
	output logic      [1:0]         o_err
);

	// ==================================================================
	// Parity bit makes the count of ones in half plus parity odd
	assign o_par[1] = ~^i_wdata[31:16];
	assign o_par[0] = ~^i_wdata[15:0];

	// Even count across half plus stored parity is an error
	assign o_err[1] = ~^{i_rword.data_hi, i_rword.par_hi};
	assign o_err[0] = ~^{i_rword.data_lo, i_rword.par_lo};

endmodule

// *** mbc_bank.sv ***
// Control logic for one autonomous four-port storage bank
//
// Contract
// - Each location holds 36 bits: 32 data, two marker, two parity.
// - Data usable as full word or two halves, each with parity and marker.
// - 16-bit address, decoded per bank capacity of 8192 or 16,384 words.
// - Bank gives independent access to up to four requesting sources.
// - Request selects read/write, halves and marker bits; bank does exactly that. Register-zone writes pass the whole word, halves ignored.
// - Simultaneous requests to the bank are served one after the other.
// - Half transfer carries one parity bit, full word carries two.
// - Parity is odd over each 16-bit half plus its parity bit.
// - Writes generate and store parity internally, none from requester.
// - Read parity error lights indicator and raises parity-failure interrupt.
// - Word pairs are sequential requests; sub-word fields selected inside words.
// - Octal 0-7 reserved for accumulator, save register and index registers.
// - Octal 10-27 reserved for the sixteen-entry scratch file.
// - Octal 40-60 reserved for internal interrupt line locations.
// - Octal 61-460 hold external interrupt locations, usable as storage.
// - Address 0 reaches accumulator, address 1 reaches save register.
// - Options absent: their reserved addresses fall back to core storage.
// - Scratch file is 16 x (32 data + 2 marker), 250 ns access.
// - Different banks serve different requesters at the same time.
// - A requester may start on this bank while busy on another.
// - Many requesters alternate on one bank, run parallel on others.
// - Full cycle 2 us, read data 750 ns after access begins.
// - Memory has one to four banks of either capacity, mixed.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module mbc_bank #(
	parameter int unsigned NP    = mbc_pkg::NPORTS,
	parameter int unsigned WORDS = mbc_pkg::WORDS
) (
	// Clock and reset
	input  wire logic                            i_clk,
	input  wire logic                            i_sys_rst,
	// Request ports, one per source
	input  wire logic             [NP-1:0]       i_req_vld,
	input  wire mbc_pkg::mbc_req_t [NP-1:0]      i_req,
	output logic                  [NP-1:0]       o_ack,
	output mbc_pkg::mbc_rsp_t                    o_rsp,
	// Configuration straps from pins
	input  wire logic                            i_big_bank,
	input  wire logic             [2:0]          i_bank_base,
	input  wire logic                            i_index_fitted,
	input  wire logic                            i_scratch_fitted,
	// Processor hardware registers at the lowest addresses
	output logic                                 o_hreg_wr,
	output logic                                 o_hreg_rd,
	output logic                  [2:0]          o_hreg_sel,
	output logic                  [31:0]         o_hreg_wdata,
	input  wire logic             [31:0]         i_hreg_rdata,
	// Parity indicator and interrupt
	output logic                                 o_par_led,
	input  wire logic                            i_par_led_clr,
	output logic                                 o_par_irq,
	input  wire logic                            i_diag_bad_par,
	// Status
	output logic                                 o_busy,
	output mbc_pkg::mbc_zone_t                   o_zone
);

	localparam int unsigned OFF_W = $clog2(WORDS);
	localparam int unsigned PI_W  = $clog2(NP);

	typedef enum {ST_IDLE, ST_CYCLE} mbc_state_t;

	// ==================================================================
	// Decode helpers
	// Bank hit: the field above the word offset must match this bank's base
	function automatic logic bank_hit(input logic [15:0] a, input logic big,
		input logic [2:0] base);
		if (big) begin
			bank_hit = (a[15:mbc_pkg::BIG_LSB] == base[2:1]);
		end else begin
			bank_hit = (a[15:mbc_pkg::SMALL_LSB] == base);
		end
	endfunction

	// Which store answers an address, given the fitted options
	function automatic mbc_pkg::mbc_zone_t zone_of(input logic [15:0] a,
		input logic idx_fit, input logic scr_fit);
		if (a == mbc_pkg::A_ACC || a == mbc_pkg::A_SAVE) begin
			zone_of = mbc_pkg::Z_HREG;
		end else if (a >= mbc_pkg::A_IDX_LO && a <= mbc_pkg::A_IDX_HI && idx_fit) begin
			zone_of = mbc_pkg::Z_HREG;
		end else if (a >= mbc_pkg::A_SCR_LO && a <= mbc_pkg::A_SCR_HI && scr_fit) begin
			zone_of = mbc_pkg::Z_SCR;
		end else if (a >= mbc_pkg::A_INTI_LO && a <= mbc_pkg::A_INTI_HI) begin
			zone_of = mbc_pkg::Z_INTI;
		end else if (a >= mbc_pkg::A_INTX_LO && a <= mbc_pkg::A_INTX_HI) begin
			zone_of = mbc_pkg::Z_INTX;
		end else begin
			zone_of = mbc_pkg::Z_CORE;
		end
	endfunction

	// ==================================================================
	// Strap synchroniser; straps come from pins, so two flops first
	logic [mbc_pkg::STRAP_W-1:0] strap_meta_reg;
	logic [mbc_pkg::STRAP_W-1:0] strap_reg;
	logic                        big_bank;
	logic [2:0]                  bank_base;
	logic                        idx_fit;
	logic                        scr_fit;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			strap_meta_reg <= '0;
			strap_reg      <= '0;
		end else begin
			strap_meta_reg <= {i_big_bank, i_bank_base, i_index_fitted, i_scratch_fitted};
			strap_reg      <= strap_meta_reg;
		end
	end

	assign big_bank  = strap_reg[5];
	assign bank_base = strap_reg[4:2];
	assign idx_fit   = strap_reg[1];
	assign scr_fit   = strap_reg[0];

	// ==================================================================
	// State registers
	mbc_state_t             state_reg;
	mbc_state_t             state_next;
	logic [mbc_pkg::CNT_W-1:0] cnt_reg;
	logic [mbc_pkg::CNT_W-1:0] cnt_next;
	mbc_pkg::mbc_req_t      cur_reg;
	logic [PI_W-1:0]        port_reg;
	mbc_pkg::mbc_zone_t     zone_reg;
	logic [OFF_W-1:0]       off_reg;
	logic [NP-1:0]          ack_reg;
	mbc_pkg::mbc_rsp_t      rsp_reg;
	logic                   led_reg;
	logic                   irq_reg;
	logic                   hwr_reg;
	logic                   hrd_reg;
	logic [2:0]             hsel_reg;
	logic [31:0]            hwd_reg;

	// ==================================================================
	// Per-port eligibility: requests for other banks are never seen
	logic [NP-1:0]          eligible;

	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_elig
			// Acked port is masked for the cycle its ack stands
			assign eligible[gp] = i_req_vld[gp] && !ack_reg[gp]
				&& bank_hit(i_req[gp].addr, big_bank, bank_base);
		end
	endgenerate

	// ==================================================================
	// Arbitration, only while the bank is free
	logic [NP-1:0]          gnt;
	logic [PI_W-1:0]        gnt_idx;
	logic                   gnt_any;
	logic                   take;

	mbc_arb #(
		.N      (NP)
	) u_arb (
		.i_req  (eligible),
		.i_en   (state_reg == ST_IDLE),
		.o_gnt  (gnt),
		.o_idx  (gnt_idx),
		.o_any  (gnt_any)
	);

	// One request at a time; the rest keep waiting at their port
	assign take = gnt_any;

	// ==================================================================
	// Granted request decode
	mbc_pkg::mbc_req_t      gnt_req;
	mbc_pkg::mbc_zone_t     gnt_zone;
	logic [OFF_W-1:0]       gnt_off;

	assign gnt_req  = i_req[gnt_idx];
	assign gnt_zone = zone_of(gnt_req.addr, idx_fit, scr_fit);
	// 8K banks leave the top offset bit clear
	assign gnt_off  = big_bank ? OFF_W'(gnt_req.addr[mbc_pkg::BIG_LSB-1:0])
		: OFF_W'(gnt_req.addr[mbc_pkg::SMALL_LSB-1:0]);

	// ==================================================================
	// Timing of the current cycle: core is slow, fast paths are short
	logic                   fast;
	logic [mbc_pkg::CNT_W-1:0] acc_lim;
	logic [mbc_pkg::CNT_W-1:0] end_lim;
	logic                   act;
	logic                   done;

	assign fast    = (zone_reg == mbc_pkg::Z_HREG) || (zone_reg == mbc_pkg::Z_SCR);
	assign acc_lim = fast ? mbc_pkg::CNT_W'(mbc_pkg::SCR_CYC)
		: mbc_pkg::CNT_W'(mbc_pkg::ACC_CYC);
	assign end_lim = fast ? mbc_pkg::CNT_W'(mbc_pkg::FAST_END)
		: mbc_pkg::CNT_W'(mbc_pkg::CYCLE_CYC);
	assign act     = (state_reg == ST_CYCLE) && (cnt_reg == acc_lim - 1'b1);
	assign done    = (state_reg == ST_CYCLE) && (cnt_reg == end_lim - 2'd2);

	// ==================================================================
	// State machine
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				cnt_next = '0;
				if (take) begin
					state_next = ST_CYCLE;
				end
			end
			ST_CYCLE: begin
				cnt_next = cnt_reg + 1'b1;
				if (done) begin
					state_next = ST_IDLE;
					cnt_next   = '0;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Control registers
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
			cur_reg   <= '0;
			port_reg  <= '0;
			zone_reg  <= mbc_pkg::Z_CORE;
			off_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (take) begin
				cur_reg  <= gnt_req;
				port_reg <= gnt_idx;
				zone_reg <= gnt_zone;
				off_reg  <= gnt_off;
			end
		end
	end

	// ==================================================================
	// Storage: core words carry parity, the scratch file does not
	mbc_pkg::mbc_word_t     core_mem [WORDS];
	logic [33:0]            scr_mem  [mbc_pkg::SCR_N];
	mbc_pkg::mbc_word_t     rword;
	mbc_pkg::mbc_word_t     wword;
	logic [33:0]            sword;
	logic [33:0]            snew;
	logic [1:0]             gpar;
	logic [1:0]             perr;
	logic                   is_core;
	logic                   is_wr;
	logic [3:0]             scr_idx;

	assign is_core = !fast;
	assign is_wr   = (cur_reg.op == mbc_pkg::OP_WRITE);
	assign rword   = core_mem[off_reg];
	assign scr_idx = cur_reg.addr[3:0] - mbc_pkg::A_SCR_LO[3:0];
	assign sword   = scr_mem[scr_idx];

	mbc_par u_par (
		.i_wdata (cur_reg.wdata),
		.i_rword (rword),
		.o_par   (gpar),
		.o_err   (perr)
	);

	// Merge of a write into the old word, half by half; parity is ours alone
	always_comb begin
		wword = rword;
		if (cur_reg.sel_hi) begin
			wword.data_hi = cur_reg.wdata[31:16];
			wword.par_hi  = gpar[1] ^ i_diag_bad_par;
		end
		if (cur_reg.sel_lo) begin
			wword.data_lo = cur_reg.wdata[15:0];
			wword.par_lo  = gpar[0] ^ i_diag_bad_par;
		end
		if (cur_reg.sel_exec) begin
			wword.exec_hi = cur_reg.wexec[1];
			wword.exec_lo = cur_reg.wexec[0];
		end
	end

	// Scratch entry merge: 32 data and 2 marker bits
	always_comb begin
		snew = sword;
		if (cur_reg.sel_hi) begin
			snew[31:16] = cur_reg.wdata[31:16];
		end
		if (cur_reg.sel_lo) begin
			snew[15:0] = cur_reg.wdata[15:0];
		end
		if (cur_reg.sel_exec) begin
			snew[33:32] = cur_reg.wexec;
		end
	end

	// Array writes; storage is data and needs no reset
	always_ff @(posedge i_clk) begin
		if (act && is_wr && is_core) begin
			core_mem[off_reg] <= wword;
		end
		if (act && is_wr && zone_reg == mbc_pkg::Z_SCR) begin
			scr_mem[scr_idx] <= snew;
		end
	end

	// ==================================================================
	// Read answer, masked to exactly the parts that were asked for
	mbc_pkg::mbc_rsp_t      rsp_next;
	logic [31:0]            src_data;
	logic [1:0]             src_exec;
	logic [1:0]             sel_mask;
	logic                   par_fail;

	assign sel_mask = {cur_reg.sel_hi, cur_reg.sel_lo};
	assign src_data = (zone_reg == mbc_pkg::Z_HREG) ? i_hreg_rdata
		: (zone_reg == mbc_pkg::Z_SCR) ? sword[31:0]
		: {rword.data_hi, rword.data_lo};
	assign src_exec = (zone_reg == mbc_pkg::Z_HREG) ? 2'h0
		: (zone_reg == mbc_pkg::Z_SCR) ? sword[33:32]
		: {rword.exec_hi, rword.exec_lo};
	// Only halves actually read are checked; writes never flag
	assign par_fail = act && !is_wr && is_core && |(perr & sel_mask);

	always_comb begin
		rsp_next       = '0;
		rsp_next.rdata = {sel_mask[1] ? src_data[31:16] : 16'h0000,
			sel_mask[0] ? src_data[15:0] : 16'h0000};
		rsp_next.rexec = cur_reg.sel_exec ? src_exec : 2'h0;
		rsp_next.perr  = is_core ? (perr & sel_mask) : 2'h0;
	end

	// Answer and ack registers; ack is a pulse on the served port only
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ack_reg <= '0;
			rsp_reg <= '0;
		end else begin
			ack_reg <= '0;
			if (act) begin
				ack_reg[port_reg] <= 1'b1;
				if (!is_wr) begin
					rsp_reg <= rsp_next;
				end
			end
		end
	end

	// ==================================================================
	// Hardware register port; select held for the whole fast cycle
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hwr_reg  <= 1'b0;
			hrd_reg  <= 1'b0;
			hsel_reg <= 3'h0;
			hwd_reg  <= 32'h0000_0000;
		end else begin
			hwr_reg <= act && is_wr && zone_reg == mbc_pkg::Z_HREG;
			hrd_reg <= act && !is_wr && zone_reg == mbc_pkg::Z_HREG;
			if (take) begin
				hsel_reg <= gnt_req.addr[2:0];
				hwd_reg  <= gnt_req.wdata;
			end
		end
	end

	// ==================================================================
	// Parity indicator is sticky; a new error beats a clear
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			led_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			led_reg <= par_fail || (led_reg && !i_par_led_clr);
			irq_reg <= par_fail;
		end
	end

	// ==================================================================
	// Outputs; every bank is its own instance with its own timing, so
	// separate banks overlap and serve different sources freely
	assign o_ack        = ack_reg;
	assign o_rsp        = rsp_reg;
	assign o_hreg_wr    = hwr_reg;
	assign o_hreg_rd    = hrd_reg;
	assign o_hreg_sel   = hsel_reg;
	assign o_hreg_wdata = hwd_reg;
	assign o_par_led    = led_reg;
	assign o_par_irq    = irq_reg;
	assign o_busy       = (state_reg == ST_CYCLE);
	// Zone of the cycle in progress, internal interrupt area included
	assign o_zone       = zone_reg;

endmodule

// *** mbc_bank_props.sv ***
// Concurrent checks on the bank controller ports
`timescale 1ns/100ps
module mbc_bank_chk (
	// Clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_sys_rst,
	// Observed ports
	input  wire logic [3:0]         i_req_vld,
	input  wire logic [3:0]         o_ack,
	input  wire mbc_pkg::mbc_rsp_t  o_rsp,
	input  wire logic               o_par_led,
	input  wire logic               i_par_led_clr,
	input  wire logic               o_par_irq,
	input  wire logic               o_hreg_wr,
	input  wire logic               o_hreg_rd,
	input  wire logic               o_busy,
	input  wire mbc_pkg::mbc_zone_t o_zone
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// ==================================================================
	// Helpers
	wire any_ack = |o_ack;
	wire core_z  = (o_zone == mbc_pkg::Z_CORE);
	wire fast_z  = (o_zone == mbc_pkg::Z_HREG) || (o_zone == mbc_pkg::Z_SCR);
	// ==================================================================
	// Assertions
	ack_onehot_a: assert property ($onehot0(o_ack))
		else $error("two ports acked together");
	ack_cause_a: assert property (any_ack |-> (o_ack & $past(i_req_vld)) == o_ack)
		else $error("ack without a request");
	core_lat_a: assert property ($rose(o_busy) && core_z |-> !any_ack[*8] ##1 any_ack)
		else $error("core ack not eight cycles after grant");
	fast_lat_a: assert property ($rose(o_busy) && fast_z |-> !any_ack[*3] ##1 any_ack)
		else $error("fast ack not three cycles after grant");
	core_gap_a: assert property (any_ack && core_z |=> !any_ack[*8])
		else $error("core cycle cut short");
	rsp_hold_a: assert property ($changed(o_rsp) |-> any_ack)
		else $error("response changed without ack");
	irq_cause_a: assert property (o_par_irq |-> o_par_led && any_ack && o_rsp.perr != 2'b00)
		else $error("parity interrupt without error");
	irq_pulse_a: assert property (o_par_irq |=> !o_par_irq)
		else $error("parity interrupt longer than a cycle");
	led_hold_a: assert property (o_par_led && !i_par_led_clr |=> o_par_led)
		else $error("parity indicator lost");
	hreg_wr_a: assert property (o_hreg_wr |-> any_ack && o_zone == mbc_pkg::Z_HREG)
		else $error("register write outside its zone");
	hreg_rd_a: assert property (o_hreg_rd |-> any_ack && o_zone == mbc_pkg::Z_HREG)
		else $error("register read outside its zone");
	// Main scenarios reached
	cover property (any_ack && core_z);
	cover property (o_par_irq);
	cover property (o_hreg_wr);
endmodule

bind mbc_bank mbc_bank_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_vld(i_req_vld),
	.o_ack(o_ack), .o_rsp(o_rsp), .o_par_led(o_par_led), .i_par_led_clr(i_par_led_clr),
	.o_par_irq(o_par_irq), .o_hreg_wr(o_hreg_wr), .o_hreg_rd(o_hreg_rd), .o_busy(o_busy),
	.o_zone(o_zone));

// *** mbc_hreg_model.sv ***
// Processor hardware registers answering the lowest addresses
`timescale 1ns/100ps
module mbc_hreg_model (
	// Clock
	input  wire logic        i_clk,
	// Register port
	input  wire logic        i_wr,
	input  wire logic [2:0]  i_sel,
	input  wire logic [31:0] i_wdata,
	output logic      [31:0] o_rdata
);
	logic [31:0] regs [0:7];
	// Accumulator, save and index registers; unwritten ones read unknown
	always_ff @(posedge i_clk) begin
		if (i_wr) begin
			regs[i_sel] <= i_wdata;
		end
	end
	// Read is combinational from the select
	assign o_rdata = regs[i_sel];
endmodule

// *** mbc_bank_tb.sv ***
// Self-checking testbench for the memory bank controller
`timescale 1ns/100ps
module mbc_bank_tb;
	logic clk = 0, rst = 1, clr = 0, bad = 0, hwr, busy;
	logic [3:0] vld = '0, ack;
	mbc_pkg::mbc_req_t [3:0] req = '0;
	mbc_pkg::mbc_rsp_t rsp;
	mbc_pkg::mbc_zone_t zone;
	logic [2:0] hsel;
	logic [31:0] hwd, hrd;
	logic led, irq;
	logic strap_big = 1, strap_idx = 1, strap_scr = 1;
	int errors = 0, checks_done = 0, cyc = 0, lat, i, t1, t3;
	int fa[3] = '{0, 1, 8};
	// ==================================================================
	// Design and partner
	mbc_bank i_dut (.i_clk(clk), .i_sys_rst(rst), .i_req_vld(vld), .i_req(req), .o_ack(ack),
		.o_rsp(rsp), .i_big_bank(strap_big), .i_bank_base(3'h0), .i_index_fitted(strap_idx),
		.i_scratch_fitted(strap_scr), .o_hreg_wr(hwr), .o_hreg_rd(), .o_hreg_sel(hsel),
		.o_hreg_wdata(hwd), .i_hreg_rdata(hrd), .o_par_led(led), .i_par_led_clr(clr),
		.o_par_irq(irq), .i_diag_bad_par(bad), .o_busy(busy), .o_zone(zone));
	mbc_hreg_model i_regs (.i_clk(clk), .i_wr(hwr), .i_sel(hsel), .i_wdata(hwd), .o_rdata(hrd));
	// ==================================================================
	// Clock and watchdog; a hang counts as a mismatch
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Waits for idle so latencies are measured from a free bank
	task automatic idle();
		@(negedge clk);
		while (busy !== 1'b0) @(negedge clk);
		@(posedge clk);
	endtask
	// One request held until its ack; lat is the access time plus two:
	// one edge from launch to grant, one half-cycle to see the ack
	task automatic acc(input int p, input logic w, input logic [2:0] s, input logic [15:0] a,
			input logic [31:0] d, input logic [1:0] e);
		idle();
		req[p] <= '{mbc_pkg::mbc_op_t'(w), s[2], s[1], s[0], a, d, e};
		vld[p] <= 1'b1;
		lat = 0;
		do begin
			@(negedge clk);
			lat++;
		end while (ack[p] !== 1'b1 && lat < 60);
		@(posedge clk);
		vld[p] <= 1'b0;
	endtask
	// ==================================================================
	// Scenarios
	task automatic t_core();
		acc(0, 1, 3'b111, 16'h0100, 32'h1234_5678, 2'b10);
		chk("write lat", mbc_pkg::ACC_CYC + 2, lat);
		acc(1, 1, 3'b100, 16'h0100, 32'hbeef_0000, 2'b00);
		acc(2, 1, 3'b001, 16'h0100, 32'h0, 2'b01);
		acc(0, 0, 3'b111, 16'h0100, 32'h0, 2'b00);
		chk("read lat", mbc_pkg::ACC_CYC + 2, lat);
		chk("word", {2'b01, 32'hbeef_5678}, {rsp.rexec, rsp.rdata});
		chk("perr", 0, rsp.perr);
		acc(3, 0, 3'b010, 16'h0100, 32'h0, 2'b00);
		chk("low half", {2'b00, 32'h0000_5678}, {rsp.rexec, rsp.rdata});
		acc(0, 1, 3'b111, 16'h0031, 32'h1, 2'b00);
		chk("zone", mbc_pkg::Z_INTX, zone);
		$display("test core done");
	endtask
	task automatic t_par();
		bad <= 1'b1;
		acc(0, 1, 3'b111, 16'h0200, 32'h0000_0001, 2'b00);
		bad <= 1'b0;
		acc(0, 0, 3'b111, 16'h0200, 32'h0, 2'b00);
		chk("bad perr", 2'b11, rsp.perr);
		chk("led on", 1, led);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		@(negedge clk);
		chk("led off", 0, led);
		$display("test parity done");
	endtask
	task automatic t_coll();
		idle();
		req[1] <= '{mbc_pkg::OP_READ, 1'b1, 1'b1, 1'b0, 16'h0100, 32'h0, 2'b00};
		req[3] <= '{mbc_pkg::OP_READ, 1'b1, 1'b1, 1'b0, 16'h0100, 32'h0, 2'b00};
		vld[1] <= 1'b1;
		vld[3] <= 1'b1;
		t1 = 0;
		t3 = 0;
		for (i = 1; i < 80; i++) begin
			@(negedge clk);
			if (ack[1] === 1'b1) t1 = i;
			if (ack[3] === 1'b1) t3 = i;
			@(posedge clk);
			if (t1 == i) vld[1] <= 1'b0;
			if (t3 == i) vld[3] <= 1'b0;
		end
		chk("first", mbc_pkg::ACC_CYC + 2, t1);
		chk("spacing", mbc_pkg::CYCLE_CYC, t3 - t1);
		$display("test collision done");
	endtask
	task automatic t_fast();
		foreach (fa[k]) begin
			acc(k, 1, 3'b111, fa[k][15:0], 32'ha5a5_0000 + fa[k], 2'b11);
			chk("fast lat", mbc_pkg::SCR_CYC + 2, lat);
			acc(k, 0, 3'b111, fa[k][15:0], 32'h0, 2'b00);
			chk("fast data", 32'ha5a5_0000 + fa[k], rsp.rdata);
			chk("fast zone", (fa[k] < 2) ? mbc_pkg::Z_HREG : mbc_pkg::Z_SCR, zone);
		end
		$display("test fast done");
	endtask
	task automatic t_bank(input logic [15:0] a);
		idle();
		req[2] <= '{mbc_pkg::OP_READ, 1'b1, 1'b1, 1'b0, a, 32'h0, 2'b00};
		vld[2] <= 1'b1;
		t1 = 0;
		repeat (30) begin
			@(negedge clk);
			if (ack !== 4'h0) t1++;
		end
		@(posedge clk);
		vld[2] <= 1'b0;
		chk("foreign", 0, t1);
		$display("test bank done");
	endtask
	// Options absent and an 8K bank: their reserved addresses fall back to core
	task automatic t_strap();
		strap_big <= 1'b0;
		strap_idx <= 1'b0;
		strap_scr <= 1'b0;
		repeat (3) @(posedge clk);
		acc(1, 1, 3'b111, 16'h0008, 32'h0bad_cafe, 2'b01);
		chk("plain lat", mbc_pkg::ACC_CYC + 2, lat);
		chk("plain zone", mbc_pkg::Z_CORE, zone);
		acc(3, 0, 3'b111, 16'h0008, 32'h0, 2'b00);
		chk("plain data", {2'b01, 32'h0bad_cafe}, {rsp.rexec, rsp.rdata});
		acc(2, 1, 3'b111, 16'h0003, 32'h0, 2'b00);
		chk("index zone", mbc_pkg::Z_CORE, zone);
		acc(2, 1, 3'b111, 16'h0020, 32'h0, 2'b00);
		chk("int zone", mbc_pkg::Z_INTI, zone);
		t_bank(16'h2000);
		$display("test strap done");
	endtask
	// ==================================================================
	// Verdict, the only place the run ends
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_core();
		t_par();
		t_coll();
		t_fast();
		t_bank(16'h4000);
		t_strap();
		results();
	end
endmodule
